// >>> hw/ost_map.svh
// What this block does
// - one-shot counts down per tick after trigger
// - at zero reload counter, then stop
// - retrigger while running reloads and restarts
// - one-shot start: pin, overflow, one-shot flag
// - one-shot ends after zero reload or flag clear
// - one-shot interrupt request when reaching zero
// - pins selectable as port or timer function
// - value register reads are undefined
// - write while stopped loads reload and counter
// - write while running loads reload only
// - pwm counts down, 8-bit or 16-bit
// - pwm reloads at each rising edge, continues
// - pwm ignores triggers once running
// - 16-bit pwm high n, period 65535
// - 8-bit pwm high n(m+1), period 255(m+1)
// - pwm start: pin, overflow, start flag
// - pwm stops only when start flag cleared
// - pwm interrupt request on falling output
// - one-shot stop: reload, output low, request
// - external trigger synchronised to count source
// - retrigger: one more down count, then reload
// - pwm stop when high: low plus request
`ifndef OST_MAP_SVH
`define OST_MAP_SVH
`define OST_ADR_VALUE 4'h0
`define OST_ADR_CTRL 4'h4
`define OST_ADR_STAT 4'h8
`define OST_CTRL_START 0
`define OST_CTRL_ONESHOT 1
`define OST_CTRL_PWM 2
`define OST_CTRL_PWM8 3
`define OST_CTRL_SRC 5:4
`define OST_CTRL_TRIG 7:6
`define OST_CTRL_OUTEN 8
`define OST_CTRL_GPIO 9
`define OST_STAT_IRQ 0
`define OST_STAT_RUN 1
`define OST_STAT_OUT 2
`define OST_STAT_PIN 3
`define OST_RST_CTRL 16'h0000
`define OST_RST_VALUE 16'h0000
`define OST_DIV8 5'h07
`define OST_DIV32 5'h1f
`define OST_PER16 16'hfffe
`define OST_PER8 16'h00fe
`endif

// >>> hw/ost_pkg.sv
package ost_pkg;
  typedef enum logic [1:0] {
    OST_IDLE = 2'b01,
    OST_RUN = 2'b10
  } ost_state_t;
  typedef enum logic [1:0] {
    OST_SRC_DIV1 = 2'h0,
    OST_SRC_DIV8 = 2'h1,
    OST_SRC_DIV32 = 2'h2,
    OST_SRC_SUB32 = 2'h3
  } ost_src_t;
  typedef enum logic [1:0] {
    OST_TRIG_SW = 2'h0,
    OST_TRIG_PIN = 2'h1,
    OST_TRIG_OVF = 2'h2
  } ost_trig_t;
endpackage : ost_pkg

// >>> hw/ost_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "ost_map.svh"
module ost_prescaler
  import ost_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // selection
  input wire logic [1:0] src_sel,
  // subclock pin, asynchronous
  input wire logic sub_clk,
  // one-cycle tick
  output logic tick
);
  logic [4:0] div_cnt;
  logic [4:0] sub_cnt;
  logic sub_m;
  logic sub_s;
  logic sub_d;
  logic sub_edge;
  assign sub_edge = sub_s & ~sub_d;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sub_m <= 1'b0;
      sub_s <= 1'b0;
      sub_d <= 1'b0;
      sub_cnt <= 5'h00;
    end else begin
      sub_m <= sub_clk;
      sub_s <= sub_m;
      sub_d <= sub_s;
      if (sub_edge) begin
        sub_cnt <= sub_cnt + 5'h01;
      end
    end
  end
  always_comb begin
    case (ost_src_t'(src_sel))
      OST_SRC_DIV1: tick = 1'b1;
      OST_SRC_DIV8: tick = ((div_cnt & `OST_DIV8) == `OST_DIV8);
      OST_SRC_DIV32: tick = (div_cnt == `OST_DIV32);
      OST_SRC_SUB32: tick = sub_edge && (sub_cnt == `OST_DIV32);
      default: tick = 1'b0;
    endcase
  end
endmodule : ost_prescaler
`default_nettype wire

// >>> hw/ost_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "ost_map.svh"
module ost_timer
  import ost_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic timer_trigger_input,
  input wire logic sub_clk,
  output logic timer_pulse_output,
  // neighbour timer overflow pulse
  input wire logic timer_overflow_in,
  // interrupt request pulse
  output logic timer_irq_req
);
  if (WIDTH != 16) begin : g_width_check
    $error("ost_timer serves only a 16-bit counter");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  function automatic logic hit(input logic [3:0] adr,
                               input logic [3:0] off);
    hit = (adr == off);
  endfunction : hit

  ost_state_t state;
  logic [15:0] ctrl;
  logic [15:0] reload;
  logic [15:0] cnt;
  logic [15:0] per_cnt;
  logic [7:0] pre_cnt;
  logic [7:0] pre_m;
  logic pulse;
  logic irq_flag;
  logic retrig;
  logic trig_pend;
  logic trig_m;
  logic trig_s;
  logic trig_d;
  logic tick;
  logic bus_req;
  logic wr;
  logic wr_value;
  logic wr_ctrl;
  logic wr_stat;
  logic sw_shot;
  logic start_fall;
  logic running;
  logic is_pwm;
  logic is_pwm8;
  logic unit_tick;
  logic [15:0] per_last;
  logic evt_zero;
  logic evt_stop;
  logic evt_fall;
  logic trig_evt;
  logic enter;
  logic [15:0] next_ctrl;
  logic [15:0] next_cnt;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr = bus_req & wb_we_i & ~wb_ack_o;
  assign wr_value = wr & hit(wb_adr_i, `OST_ADR_VALUE);
  assign wr_ctrl = wr & hit(wb_adr_i, `OST_ADR_CTRL);
  assign wr_stat = wr & hit(wb_adr_i, `OST_ADR_STAT);
  assign next_ctrl = merge16(ctrl, wb_dat_i, wb_sel_i);
  assign sw_shot = wr_ctrl & next_ctrl[`OST_CTRL_ONESHOT];
  assign start_fall = wr_ctrl & ctrl[`OST_CTRL_START]
                      & ~next_ctrl[`OST_CTRL_START];
  assign running = (state == OST_RUN);
  assign is_pwm = ctrl[`OST_CTRL_PWM];
  assign is_pwm8 = ctrl[`OST_CTRL_PWM8];
  assign per_last = is_pwm8 ? `OST_PER8 : `OST_PER16;
  assign enter = ctrl[`OST_CTRL_START] & ~start_fall
                 & ((is_pwm & (ctrl[`OST_CTRL_TRIG] == OST_TRIG_SW))
                    | (tick & trig_pend));

  // bus answer, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // read data; value reads show counter, not guaranteed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        `OST_ADR_VALUE: wb_dat_o[15:0] <= cnt;
        `OST_ADR_CTRL: wb_dat_o[15:0] <= ctrl;
        `OST_ADR_STAT: begin
          wb_dat_o[`OST_STAT_IRQ] <= irq_flag;
          wb_dat_o[`OST_STAT_RUN] <= running;
          wb_dat_o[`OST_STAT_OUT] <= pulse;
          wb_dat_o[`OST_STAT_PIN] <= trig_s;
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // control register; one-shot flag is self-clearing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= `OST_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
      ctrl[`OST_CTRL_ONESHOT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reload <= `OST_RST_VALUE;
    end else if (wr_value) begin
      reload <= merge16(reload, wb_dat_i, wb_sel_i);
    end
  end

  ost_prescaler u_pre (
    .ref_clk(ref_clk),
    .srst(srst),
    .src_sel(ctrl[`OST_CTRL_SRC]),
    .sub_clk(sub_clk),
    .tick(tick)
  );

  // trigger pin synchroniser and edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trig_m <= 1'b0;
      trig_s <= 1'b0;
      trig_d <= 1'b0;
    end else begin
      trig_m <= timer_trigger_input;
      trig_s <= trig_m;
      trig_d <= trig_s;
    end
  end

  always_comb begin
    case (ost_trig_t'(ctrl[`OST_CTRL_TRIG]))
      OST_TRIG_SW: trig_evt = is_pwm ? 1'b0 : sw_shot;
      OST_TRIG_PIN: trig_evt = trig_s & ~trig_d;
      OST_TRIG_OVF: trig_evt = timer_overflow_in;
      default: trig_evt = 1'b0;
    endcase
  end

  // trigger held until the next count-source tick
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trig_pend <= 1'b0;
    end else if ((~ctrl[`OST_CTRL_START]
                  & ~(wr_ctrl & next_ctrl[`OST_CTRL_START]))
                 | (tick & ~trig_evt)) begin
      trig_pend <= 1'b0;
    end else if (trig_evt) begin
      trig_pend <= 1'b1;
    end
  end

  // pwm prescaler for 8-bit mode
  assign unit_tick = tick & (~is_pwm8 | (pre_cnt == 8'h00));
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pre_cnt <= 8'h00;
    end else if (~running | (tick & pre_cnt == 8'h00)) begin
      pre_cnt <= pre_m;
    end else if (tick) begin
      pre_cnt <= pre_cnt - 8'h01;
    end
  end

  // events of the count
  assign evt_stop = running & start_fall;
  assign evt_zero = running & ~is_pwm & tick & ~retrig
                    & (cnt <= 16'h0001);
  assign evt_fall = running & is_pwm & unit_tick & pulse
                    & (cnt == 16'h0001);

  // run state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= OST_IDLE;
    end else begin
      case (state)
        OST_IDLE: begin
          if (enter) begin
            state <= OST_RUN;
          end
        end
        OST_RUN: begin
          if (evt_stop | evt_zero) begin
            state <= OST_IDLE;
          end
        end
        default: state <= OST_IDLE;
      endcase
    end
  end

  // retrigger: one more down count before reload
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      retrig <= 1'b0;
    end else if (~running | is_pwm | evt_stop) begin
      retrig <= 1'b0;
    end else if (tick) begin
      retrig <= trig_pend;
    end
  end

  // counter next value
  always_comb begin
    next_cnt = cnt;
    if (~running) begin
      if (wr_value) begin
        next_cnt = merge16(reload, wb_dat_i, wb_sel_i);
      end
    end else if (evt_stop) begin
      next_cnt = reload;
    end else if (~is_pwm) begin
      if (tick) begin
        if (retrig) begin
          next_cnt = reload;
        end else if (evt_zero) begin
          next_cnt = reload;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
    end else if (unit_tick) begin
      if (per_cnt == per_last) begin
        next_cnt = is_pwm8 ? {8'h00, reload[15:8]} : reload;
      end else if (cnt != 16'h0000) begin
        next_cnt = cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= `OST_RST_VALUE;
    end else begin
      cnt <= next_cnt;
    end
  end

  // pwm period position and latched prescale
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      per_cnt <= 16'h0000;
      pre_m <= 8'h00;
    end else if (~running) begin
      per_cnt <= per_last;
      pre_m <= reload[7:0];
    end else if (unit_tick) begin
      if (per_cnt == per_last) begin
        per_cnt <= 16'h0000;
        pre_m <= reload[7:0];
      end else begin
        per_cnt <= per_cnt + 16'h0001;
      end
    end
  end

  // pulse level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pulse <= 1'b0;
    end else if (~running) begin
      pulse <= enter & ~is_pwm;
    end else if (evt_stop | evt_zero) begin
      pulse <= 1'b0;
    end else if (~is_pwm) begin
      pulse <= 1'b1;
    end else if (unit_tick) begin
      if (per_cnt == per_last) begin
        pulse <= (is_pwm8 ? reload[15:8] != 8'h00
                          : reload != 16'h0000);
      end else if (evt_fall) begin
        pulse <= 1'b0;
      end
    end
  end

  // output pin: port level or pulse
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_pulse_output <= 1'b0;
    end else if (ctrl[`OST_CTRL_OUTEN]) begin
      timer_pulse_output <= pulse;
    end else begin
      timer_pulse_output <= ctrl[`OST_CTRL_GPIO];
    end
  end

  // interrupt request pulse and sticky flag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_irq_req <= 1'b0;
    end else begin
      timer_irq_req <= evt_zero
                       | evt_fall
                       | (evt_stop & (~is_pwm | pulse));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_flag <= 1'b0;
    end else if (timer_irq_req) begin
      irq_flag <= 1'b1;
    end else if (wr_stat & wb_sel_i[0] & wb_dat_i[`OST_STAT_IRQ]) begin
      irq_flag <= 1'b0;
    end
  end
endmodule : ost_timer
`default_nettype wire

// >>> tb/ost_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ost_timer_chk #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // pins
  input wire logic timer_pulse_output,
  input wire logic timer_irq_req
);
  logic req;
  logic [9:0] sh;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // shadow of control fields
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sh <= 10'h000;
    end else if (req && wb_we_i && wb_adr_i == 4'h4) begin
      sh <= wb_dat_i[9:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ack_after_req_a:
    assert property (req |=> wb_ack_o) else $error("ack late");
  ack_one_cycle_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_needs_req_a:
    assert property (wb_ack_o |-> $past(req)) else $error("stray ack");
  gpio_level_a:
    assert property (!sh[8] && $stable(sh) |-> timer_pulse_output == sh[9])
      else $error("gpio level");
  stop_forces_low_a:
    assert property (req && wb_we_i && wb_adr_i == 4'h4 && !wb_dat_i[0]
      && wb_dat_i[8] |-> ##[1:4] !timer_pulse_output) else $error("no stop");
  pwm_fall_irq_a:
    assert property ($fell(timer_pulse_output) && sh[2] && sh[8]
      && $stable(sh) |-> $past(timer_irq_req) or ##[0:1] timer_irq_req)
      else $error("fall no irq");
  shot_irq_low_a:
    assert property (timer_irq_req && !sh[2] && sh[8]
      |-> ##[0:2] !timer_pulse_output) else $error("irq but high");
  irq_one_cycle_a:
    assert property (timer_irq_req |=> !timer_irq_req) else $error("irq held");
  cover property (timer_irq_req && sh[2]);
  cover property (timer_irq_req && !sh[2]);
  cover property ($rose(timer_pulse_output) && sh[3]);
endmodule : ost_timer_chk
bind ost_timer ost_timer_chk #(.WIDTH(WIDTH)) i_ost_timer_chk (
  .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .timer_pulse_output(timer_pulse_output),
  .timer_irq_req(timer_irq_req));
`default_nettype wire

// >>> tb/ost_partner.sv
`timescale 1ns/10ps
`default_nettype none
module ost_partner (
  // clock
  input wire logic ref_clk,
  // trigger source
  input wire logic fire,
  output logic trig,
  // pulse load
  input wire logic pulse,
  output var int lastw,
  output var int lastp
);
  int hc, pc;
  logic pq;
  logic [1:0] hold;
  initial begin
    {trig, pq, hold, hc, pc, lastw, lastp} = '0;
  end
  // trigger held four cycles, low when idle
  always @(posedge ref_clk) begin
    hold <= fire ? 2'h3 : hold - 2'(hold != 2'h0);
    trig <= fire || hold != 2'h0;
    pq <= pulse;
    hc <= pulse ? hc + 1 : 0;
    pc <= pulse && !pq ? 1 : pc + 1;
    if (!pulse && hc != 0) begin
      lastw <= hc;
    end
    if (pulse && !pq) begin
      lastp <= pc;
    end
  end
endmodule : ost_partner
`default_nettype wire

// >>> tb/oneshot_pwm_timer_channel_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module oneshot_pwm_timer_channel_bench;
  logic ref_clk, srst, cyc, stb, we, fire, ovf, sub_clk, trig, ack, pout, irq;
  logic [3:0] adr;
  logic [31:0] dat, rd, dat_o;
  logic [15:0] v;
  int n_fail, comparisons, irqs, i0, lastw, lastp;
  int divs[4];
  integer seed;
  ost_timer i_ost_timer (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timer_trigger_input(trig), .sub_clk(sub_clk),
    .timer_pulse_output(pout), .timer_overflow_in(ovf), .timer_irq_req(irq));
  ost_partner i_ost_partner (.ref_clk(ref_clk), .fire(fire), .trig(trig),
    .pulse(pout), .lastw(lastw), .lastp(lastp));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    sub_clk <= ~sub_clk;
    irqs <= irqs + int'(irq);
  end
  task tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tk
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    tk(1);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    k = 0;
    do begin
      tk(1);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) n_fail++;
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task lvl(input logic l);
    int k;
    k = 0;
    while (pout !== l && k < 70000) begin
      tk(1);
      k++;
    end
    if (pout !== l) n_fail++;
  endtask : lvl
  task meas;
    lvl(1'b1);
    lvl(1'b0);
    tk(1);
  endtask : meas
  task kick(input int s);
    tk(1);
    {fire, ovf} <= (s == 1) ? 2'b10 : 2'b01;
    tk(1);
    {fire, ovf} <= 2'b00;
  endtask : kick
  function int hi(logic [15:0] x, logic p8, int d);
    return p8 ? int'(x[15:8]) * (int'(x[7:0]) + 1) * d : int'(x) * d;
  endfunction : hi
  task tally_and_finish;
    $display("counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    tk(90000);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    {srst, cyc, stb, we, fire, ovf, sub_clk} = 7'h40;
    {adr, dat, irqs, n_fail, comparisons} = '0;
    seed = 32'h619c_3985;
    divs = '{1, 8, 32, 64};
    tk(4);
    srst <= 1'b0;
    wb(1'b1, 4'hc, 32'hffff_ffff);
    wb(1'b0, 4'hc, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    for (int s = 0; s < 4; s++) begin
      v = 16'(2 + {$random(seed)} % 6);
      wb(1'b1, 4'h4, 32'h0100);
      wb(1'b1, 4'h0, {16'h0000, v});
      i0 = irqs;
      if (s == 0 || s == 3) begin
        wb(1'b1, 4'h4, 32'h0103 | s << 4);
      end else begin
        wb(1'b1, 4'h4, 32'h0101 | s << 4 | s << 6);
        kick(s);
      end
      meas;
      `CHK(lastw, hi(v, 1'b0, divs[s]))
      tk(40);
      `CHK(irqs - i0, 1)
      `CHK(pout, 1'b0)
    end
    $display("test one-shot done");
    wb(1'b1, 4'h0, 32'h0000_0014);
    wb(1'b1, 4'h4, 32'h0103);
    lvl(1'b1);
    wb(1'b1, 4'h0, 32'h0000_0005);
    meas;
    `CHK(lastw, 20)
    wb(1'b1, 4'h4, 32'h0103);
    meas;
    `CHK(lastw, 5)
    wb(1'b1, 4'h0, 32'h0000_000c);
    wb(1'b1, 4'h4, 32'h0103);
    lvl(1'b1);
    tk(3);
    wb(1'b1, 4'h4, 32'h0103);
    meas;
    `CHK(lastw > 12, 1'b1)
    wb(1'b1, 4'h4, 32'h0103);
    lvl(1'b1);
    i0 = irqs;
    wb(1'b1, 4'h4, 32'h0100);
    tk(4);
    `CHK(pout, 1'b0)
    `CHK(irqs - i0, 1)
    $display("test reload done");
    v = 16'(20 + {$random(seed)} % 20);
    wb(1'b1, 4'h0, {16'h0000, v});
    wb(1'b1, 4'h4, 32'h0145);
    i0 = irqs;
    kick(1);
    meas;
    `CHK(lastw, int'(v))
    kick(1);
    lvl(1'b1);
    tk(1);
    `CHK(lastp, 65535)
    `CHK(irqs - i0, 1)
    i0 = irqs;
    wb(1'b1, 4'h4, 32'h0100);
    tk(4);
    `CHK(pout, 1'b0)
    `CHK(irqs - i0, 1)
    $display("test pwm16 done");
    v = {8'(3 + {$random(seed)} % 4), 8'({$random(seed)} % 3)};
    wb(1'b1, 4'h0, {16'h0000, v});
    wb(1'b1, 4'h4, 32'h011d);
    meas;
    `CHK(lastw, hi(v, 1'b1, 8))
    lvl(1'b1);
    tk(1);
    `CHK(lastp, 255 * (int'(v[7:0]) + 1) * 8)
    lvl(1'b0);
    tk(4);
    i0 = irqs;
    wb(1'b1, 4'h4, 32'h0100);
    tk(8);
    `CHK(irqs - i0, 0)
    $display("test pwm8 done");
    for (int l = 0; l < 2; l++) begin
      wb(1'b1, 4'h4, l ? 32'h0200 : 32'h0000);
      tk(3);
      `CHK(pout, l[0])
    end
    wb(1'b0, 4'h0, 32'h0000_0000);
    $display("test port done");
    tally_and_finish;
  end
endmodule : oneshot_pwm_timer_channel_bench
`default_nettype wire
